// ===== core/dac_front_end.sv
// Converter front end: captures samples, formats, and models output currents
`timescale 1ns/1ps
`default_nettype none
`include "sample_link_defs.svh"
// Overview of operation
// - Capture sample word on every rising edge
// - code_out follows capture by one clock, both currents by two
// - Strap pin selects binary or twos complement
// - Twos complement: invert only the MSB
// - All ones to positive, zeros to complementary
// - Currents proportional to code and 1023-code
// - Source clock duty cycle is free
// - Source update rate stays within limits
// - Source never asserts sleep with external amplifier
// - Sleep high powers down, open means awake
// - Source waits wake time after sleep release
module dac_front_end #(
    parameter int FS_WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [FS_WIDTH-1:0] full_scale_current,
    output logic [`SAMPLE_MSB:0] code_out,
    output logic [FS_WIDTH-1:0] positive_current_output,
    output logic [FS_WIDTH-1:0] complementary_current_output,
    output logic powered_down,
    sample_link_if.converter link
);
    // -----------------------------------------------------------------
    // Storage and pipeline taps
    // -----------------------------------------------------------------
    // Pipeline, counted in rising edges after the link word changes:
    //   edge 1  the raw word sits in the capture flops
    //   edge 2  the unsigned code sits in code_r and on code_out
    //   edge 3  both current outputs follow that code
    // The format pin passes a two-stage chain where the data passes one register,
    // so it reaches code_r one edge later; the sleep chain matches the two data registers ahead of the current gate.
    // A format strap changed on the fly therefore decodes one word with the
    // old setting; the strap is meant to be static.
    localparam int N_PINS = 2;
    localparam int PIN_FMT = 0;
    localparam int PIN_SLEEP = 1;
    localparam int PW = FS_WIDTH + `SAMPLE_WIDTH;
    localparam logic [`SAMPLE_MSB:0] CAP_RESET = `CODE_ZERO;

    logic [N_PINS-1:0] pin_raw;
    logic [N_PINS-1:0] pin_sync;
    logic fmt_sync;
    logic sleep_sync;

    logic [`SAMPLE_MSB:0] cap_word;
    logic [`SAMPLE_MSB:0] code_r;
    logic [`SAMPLE_MSB:0] code_nxt;
    logic [`SAMPLE_MSB:0] comp_code;

    logic [FS_WIDTH-1:0] pos_scaled;
    logic [FS_WIDTH-1:0] pos_r;
    logic [FS_WIDTH-1:0] pos_nxt;

    logic [FS_WIDTH-1:0] neg_scaled;
    logic [FS_WIDTH-1:0] neg_r;
    logic [FS_WIDTH-1:0] neg_nxt;
    logic pd_r;

    // -----------------------------------------------------------------
    // Decoding helpers
    // -----------------------------------------------------------------
    // Unknown pin level reads as low, standing in for the pulldown
    function automatic logic pin_level(input logic v);
        pin_level = (v === 1'b1);
    endfunction

    // Twos complement becomes the unsigned code by flipping the top bit alone
    function automatic logic [`SAMPLE_MSB:0] to_code(input logic [`SAMPLE_MSB:0] s,
                                                     input logic twos);
        to_code = s;
        if (twos == `FMT_TWOS) begin
            to_code[`SAMPLE_MSB] = ~s[`SAMPLE_MSB];
        end
    endfunction

    // Floor of fs * code / 1024: the lost fraction is below one unit of fs
    function automatic logic [FS_WIDTH-1:0] scale_current(input logic [FS_WIDTH-1:0] fs,
                                                          input logic [`SAMPLE_MSB:0] code);
        logic [PW-1:0] prod;
        prod = PW'(fs) * PW'(code);
        scale_current = prod[PW-1:`SAMPLE_WIDTH];
    endfunction

    // Forces a current to zero while the converter is powered down
    function automatic logic [FS_WIDTH-1:0] gate_current(input logic [FS_WIDTH-1:0] i,
                                                         input logic off);
        if (off) begin
            gate_current = '0;
        end else begin
            gate_current = i;
        end
    endfunction

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    // Pins pass the pulldown model before they are synchronised
    assign pin_raw[PIN_FMT] = pin_level(link.format_select);
    assign pin_raw[PIN_SLEEP] = pin_level(link.sleep_req);

    // Only the second stage of each chain is read by the logic below
    for (genvar g = 0; g < N_PINS; g++) begin : g_sync
        logic s1_r;
        logic s2_r;

        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                s1_r <= 1'b0;
            end else begin
                s1_r <= pin_raw[g];
            end
        end

        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                s2_r <= 1'b0;
            end else begin
                s2_r <= s1_r;
            end
        end

        assign pin_sync[g] = s2_r;
    end

    assign fmt_sync = pin_sync[PIN_FMT];
    assign sleep_sync = pin_sync[PIN_SLEEP];

    // -----------------------------------------------------------------
    // Capture and format
    // -----------------------------------------------------------------
    // Data shares the sample clock, so each line is captured directly
    for (genvar b = 0; b < `SAMPLE_WIDTH; b++) begin : g_cap
        logic bit_r;

        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                bit_r <= CAP_RESET[b];
            end else begin
                bit_r <= link.sample_input_bits[b];
            end
        end

        assign cap_word[b] = bit_r;
    end

    assign code_nxt = to_code(cap_word, fmt_sync);

    // Same single stage for both formats keeps latency equal
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            code_r <= `CODE_ZERO;
        end else begin
            code_r <= code_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Output current model
    // -----------------------------------------------------------------
    // Complement never underflows: code_r is at most the all-ones code
    assign comp_code = `CODE_FULL - code_r;
    assign pos_scaled = scale_current(full_scale_current, code_r);
    assign neg_scaled = scale_current(full_scale_current, comp_code);
    // Sleep gates both currents; the code path keeps running so no word is lost
    assign pos_nxt = gate_current(pos_scaled, sleep_sync);
    assign neg_nxt = gate_current(neg_scaled, sleep_sync);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pos_r <= '0;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            neg_r <= '0;
        end else begin
            neg_r <= neg_nxt;
        end
    end

    // Flag follows the same synchronised level that gates the currents
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pd_r <= 1'b0;
        end else begin
            pd_r <= sleep_sync;
        end
    end

    // -----------------------------------------------------------------
    // Outputs, each straight from a register
    // -----------------------------------------------------------------
    assign code_out = code_r;
    assign positive_current_output = pos_r;
    assign complementary_current_output = neg_r;
    assign powered_down = pd_r;
endmodule // dac_front_end
`default_nettype wire

// ===== core/sample_fifo.sv
// Small flop-based FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule // sample_fifo
`default_nettype wire

// ===== core/sample_link_defs.svh
// Constants shared by the sample source and the converter front end
`ifndef SAMPLE_LINK_DEFS_SVH
`define SAMPLE_LINK_DEFS_SVH
`define SAMPLE_WIDTH 10
`define SAMPLE_MSB 9
`define FMT_BINARY 1'h0
`define FMT_TWOS 1'h1
`define CODE_FULL 10'h3FF
`define CODE_ZERO 10'h000
`define FULL_SCALE_DIV 1024
`define CLK_PERIOD_NS 40
`define MAX_RATE_MSPS 100
`define MAX_RATE_LOW_SUPPLY_MSPS 67
`define WAKE_TIME_MS 3
`define WAKE_CYCLES ((`WAKE_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 4
`endif

// ===== core/sample_link_if.sv
// Parallel sample link between the sample source and the converter
`timescale 1ns/1ps
`default_nettype none
interface sample_link_if;
    sample_link_pkg::sample_t sample_input_bits;
    logic format_select;
    logic sleep_req;
    modport source (output sample_input_bits, output format_select, output sleep_req);
    modport converter (input sample_input_bits, input format_select, input sleep_req);
endinterface // sample_link_if
`default_nettype wire

// ===== core/sample_link_pkg.sv
// Types for the sample link: sample_t for both ends, src_state_t for the source only
package sample_link_pkg;
    typedef logic [9:0] sample_t;
    typedef enum logic [1:0] {
        SRC_AWAKE = 2'b00,
        SRC_WAKING = 2'b01,
        SRC_ASLEEP = 2'b10
    } src_state_t;
endpackage

// ===== core/sample_source.sv
// Sample source end: buffers user samples and drives the parallel link
`timescale 1ns/1ps
`default_nettype none
`include "sample_link_defs.svh"
module sample_source #(
    parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic user_valid,
    output logic user_ready,
    input wire logic [`SAMPLE_MSB:0] user_sample,
    input wire logic user_twos,
    input wire logic user_sleep,
    output logic output_ready,
    sample_link_if.source link
);
    // -----------------------------------------------------------------
    // Buffer and wake sequencing
    // -----------------------------------------------------------------
    sample_link_pkg::src_state_t state_r;
    logic [31:0] wait_r;
    logic [`SAMPLE_MSB:0] fifo_data;
    logic fifo_valid;
    logic fifo_ready;
    logic fmt_r;
    logic sleep_r;
    logic [`SAMPLE_MSB:0] data_r;
    logic rdy_r;

    // One word per clock at most, so the update rate equals clk_sys
    // (25 MSPS), below both rate ceilings
    assign fifo_ready = 1'b1;
    assign output_ready = rdy_r;

    sample_fifo #(.WIDTH(`SAMPLE_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(user_valid),
        .in_ready(user_ready),
        .in_data(user_sample),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // Format is a strap: latched only while reset is held
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fmt_r <= user_twos;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            data_r <= `CODE_ZERO;
        end else if (fifo_valid) begin
            data_r <= fifo_data;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r <= sample_link_pkg::SRC_AWAKE;
            sleep_r <= 1'b0;
            wait_r <= '0;
            rdy_r <= 1'b0;
        end else begin
            case (state_r)
                sample_link_pkg::SRC_AWAKE: begin
                    rdy_r <= 1'b1;
                    if (user_sleep) begin
                        state_r <= sample_link_pkg::SRC_ASLEEP;
                        sleep_r <= 1'b1;
                        rdy_r <= 1'b0;
                    end
                end
                sample_link_pkg::SRC_ASLEEP: begin
                    if (!user_sleep) begin
                        state_r <= sample_link_pkg::SRC_WAKING;
                        sleep_r <= 1'b0;
                        wait_r <= '0;
                    end
                end
                sample_link_pkg::SRC_WAKING: begin
                    if (user_sleep) begin
                        state_r <= sample_link_pkg::SRC_ASLEEP;
                        sleep_r <= 1'b1;
                    end else if (wait_r >= 32'(WAKE_CYCLES - 1)) begin
                        state_r <= sample_link_pkg::SRC_AWAKE;
                        rdy_r <= 1'b1;
                    end else begin
                        wait_r <= wait_r + 32'h1;
                    end
                end
                default: begin
                    state_r <= sample_link_pkg::SRC_AWAKE;
                    sleep_r <= 1'b0;
                end
            endcase
        end
    end

    // The link clock is clk_sys itself, free running, edge on every cycle
    assign link.sample_input_bits = data_r;
    assign link.format_select = fmt_r;
    assign link.sleep_req = sleep_r;
endmodule // sample_source
`default_nettype wire

// ===== sim/dac_input_capture_and_format_tb_top.sv
// Testbench joining sample source and converter front end
`timescale 1ns/1ps
`default_nettype none
module dac_input_capture_and_format_tb_top;
    logic clk_sys = 1'b0, reset = 1'b1, user_valid = 1'b0, user_twos = 1'b0, user_sleep = 1'b0;
    logic user_ready, output_ready, powered_down;
    logic [9:0] user_sample = 10'h000, code_out;
    logic [15:0] fs = 16'hC350, pos, neg;
    int n_errors = 0, check_count = 0, cycles = 0;
    sample_link_if link ();
    sample_source #(.WAKE_CYCLES(8)) sample_source_inst (.clk_sys(clk_sys), .reset(reset),
        .user_valid(user_valid), .user_ready(user_ready), .user_sample(user_sample),
        .user_twos(user_twos), .user_sleep(user_sleep), .output_ready(output_ready), .link(link));
    dac_front_end dac_front_end_inst (.clk_sys(clk_sys), .reset(reset),
        .full_scale_current(fs), .code_out(code_out), .positive_current_output(pos),
        .complementary_current_output(neg), .powered_down(powered_down), .link(link));
    sample_link_chk sample_link_chk_inst (.clk_sys(clk_sys), .reset(reset),
        .sample_input_bits(link.sample_input_bits), .format_select(link.format_select),
        .sleep_req(link.sleep_req), .code_out(code_out), .full_scale_current(fs),
        .positive_current_output(pos), .complementary_current_output(neg),
        .powered_down(powered_down));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset(input logic twos);
        reset = 1'b1;
        user_twos = twos;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        check({15'h0, output_ready}, 16'h1, "ready after reset");
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Four boundary words back to back; each code must show one cycle after the one before
    task automatic t_stream(input logic twos);
        logic [9:0] w[4] = '{10'h3FF, 10'h000, 10'h200, 10'h1FF};
        logic [9:0] c[4];
        logic [25:0] p;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            check({15'h0, user_ready}, 16'h1, "ready");
            user_valid = 1'b1;
            user_sample = w[i];
            c[i] = w[i] ^ {twos, 9'h000};
        end
        for (int k = 0; k < 5; k++) begin
            @(negedge clk_sys);
            user_valid = 1'b0;
            if (k < 4) check({6'h0, code_out}, {6'h0, c[k]}, "code");
            if (k > 0) begin
                p = fs * c[k-1];
                check(pos, p[25:10], "pos");
                p = fs * (10'h3FF - c[k-1]);
                check(neg, p[25:10], "neg");
            end
        end
    endtask
    task automatic t_sleep();
        int n = 0;
        @(negedge clk_sys);
        user_sleep = 1'b1;
        repeat (6) @(negedge clk_sys);
        check({15'h0, powered_down}, 16'h1, "asleep");
        check(pos | neg, 16'h0, "current asleep");
        check({15'h0, output_ready}, 16'h0, "ready asleep");
        user_sleep = 1'b0;
        while (!output_ready && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        check({15'h0, n >= 8 && n <= 14}, 16'h1, "wake time");
        check({15'h0, powered_down}, 16'h0, "awake");
    endtask
    initial begin
        do_reset(1'b0);
        t_stream(1'b0);
        t_sleep();
        t_stream(1'b0);
        do_reset(1'b1);
        t_stream(1'b1);
        conclude();
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            conclude();
        end
    end
endmodule // dac_input_capture_and_format_tb_top
`default_nettype wire

// ===== sim/sample_link_chk.sv
// Concurrent checks on the sample link and converter outputs
`timescale 1ns/1ps
`default_nettype none
module sample_link_chk #(
    parameter int FS_WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire sample_link_pkg::sample_t sample_input_bits,
    input wire logic format_select,
    input wire logic sleep_req,
    input wire logic [9:0] code_out,
    input wire logic [FS_WIDTH-1:0] full_scale_current,
    input wire logic [FS_WIDTH-1:0] positive_current_output,
    input wire logic [FS_WIDTH-1:0] complementary_current_output,
    input wire logic powered_down
);
    // Pipeline still holds reset-time values for a few edges
    logic [1:0] age_r;
    logic [FS_WIDTH+9:0] prod_pos;
    logic [FS_WIDTH+9:0] prod_neg;
    wire settled = (age_r == 2'h3);
    assign prod_pos = full_scale_current * code_out;
    assign prod_neg = full_scale_current * (10'h3FF - code_out);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) age_r <= 2'h0;
        else if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_CAPTURE: assert property (
        settled |-> code_out[8:0] == $past(sample_input_bits[8:0], 2))
        else $error("code low bits do not follow captured sample");
    AST_FORMAT: assert property (
        settled |-> code_out[9] == ($past(sample_input_bits[9], 2) ^ $past(format_select, 3)))
        else $error("code top bit wrong for selected format");
    AST_POS: assert property (
        settled && !powered_down && $past(!powered_down)
        |-> positive_current_output == $past(prod_pos[FS_WIDTH+9:10]))
        else $error("positive current wrong");
    AST_NEG: assert property (
        settled && !powered_down && $past(!powered_down)
        |-> complementary_current_output == $past(prod_neg[FS_WIDTH+9:10]))
        else $error("complementary current wrong");
    AST_FULL: assert property (
        settled && code_out == 10'h3FF && !powered_down ##1 !powered_down
        |-> complementary_current_output == '0)
        else $error("all-ones code leaves complementary current");
    AST_PD_ZERO: assert property (
        powered_down |-> positive_current_output == '0 && complementary_current_output == '0)
        else $error("current flows while powered down");
    AST_SLEEP: assert property ($rose(sleep_req) |-> ##[1:4] powered_down)
        else $error("sleep request not honoured");
    // One edge later than settled: the first code may still use the reset-time format
    AST_HOLD: assert property (
        settled && $past(settled)
        && $past(sample_input_bits, 2) == $past(sample_input_bits, 3)
        && $past(format_select, 3) == $past(format_select, 4)
        |-> $stable(code_out))
        else $error("code changed without new sample");
    cover property (settled && code_out == 10'h3FF);
    cover property (settled && format_select && code_out == 10'h000);
    cover property (powered_down ##1 !powered_down);
endmodule // sample_link_chk
`default_nettype wire
